// File: pmic_regs_pkg.sv
`default_nettype none
package pmic_regs_pkg;
   // Target address on the serial bus; value is arbitrary
   localparam logic [6:0] TARGET_ADDR = 7'h2a;

   // Register offsets
   localparam logic [7:0] OFS_UNLOCK_KEY = 8'h03;
   localparam logic [7:0] OFS_RESTART_CAUSE = 8'h04;
   localparam logic [7:0] OFS_SOURCE_FLAGS = 8'h05;
   localparam logic [7:0] OFS_RAIL_GOOD = 8'h06;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Unlock key and reset values
   localparam logic [7:0] UNLOCK_KEY_VALUE = 8'ha5;
   localparam logic [7:0] KEY_RESET = 8'h00;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [6:0] FLAGS_RESET = 7'h00;
   localparam logic RSVD_RESET = 1'b0;

   // Field positions in the restart cause register; RSVD_BIT is bit 0 of the source and good flag registers
   localparam int CAUSE_LSB = 4;
   localparam int BYPASS_BIT = 3;
   localparam int CLEAR_BIT = 2;
   localparam int RSVD_BIT = 0;

   // Restart cause codes, indexed by event number
   localparam int NUM_CAUSES = 9;
   localparam logic [3:0] CAUSE_FIRST_POWER_UP = 4'h0;
   localparam logic [3:0] CAUSE_POWER_DISABLE = 4'h1;
   localparam logic [3:0] CAUSE_OVER_VOLTAGE = 4'h2;
   localparam logic [3:0] CAUSE_UNDER_VOLTAGE = 4'h3;
   localparam logic [3:0] CAUSE_OVER_CURRENT = 4'h4;
   localparam logic [3:0] CAUSE_EXT_REG_ONE = 4'h5;
   localparam logic [3:0] CAUSE_EXT_REG_TWO = 4'h6;
   localparam logic [3:0] CAUSE_EXT_REG_THREE = 4'h7;
   localparam logic [3:0] CAUSE_OVER_TEMP = 4'h8;
   localparam logic [3:0] CAUSE_UNKNOWN = 4'hf;
   localparam logic [3:0] CAUSE_RESET = CAUSE_FIRST_POWER_UP;
   localparam logic [3:0] CAUSE_CODE [NUM_CAUSES] = '{
      CAUSE_FIRST_POWER_UP, CAUSE_POWER_DISABLE, CAUSE_OVER_VOLTAGE,
      CAUSE_UNDER_VOLTAGE, CAUSE_OVER_CURRENT, CAUSE_EXT_REG_ONE,
      CAUSE_EXT_REG_TWO, CAUSE_EXT_REG_THREE, CAUSE_OVER_TEMP};

   // Monitored sources: input supply, five bucks, linear regulator
   localparam int NUM_RAILS = 7;
   // Synchronised inputs: scl, sda, causes, unknown, sources, good
   localparam int SYNC_W = 2 + NUM_CAUSES + 1 + 2 * NUM_RAILS;

   // Serial target states
   typedef enum logic [7:0] {
      ST_IDLE  = 8'h01,
      ST_ADDR  = 8'h02,
      ST_PTR   = 8'h04,
      ST_WDATA = 8'h08,
      ST_ACK   = 8'h10,
      ST_ACKH  = 8'h20,
      ST_RDATA = 8'h40,
      ST_RACK  = 8'h80
   } link_state_t;
endpackage
`default_nettype wire

// File: sync2.sv
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   // Two flops per bit; only the second stage is read outside
   genvar i;
   for (i = 0; i < W; i++) begin : g_bit
      assign meta_d[i] = d[i];
      assign q_d[i] = meta_q[i];
   end

   // One register process for the whole word avoids split drivers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= meta_d;
         q <= q_d;
      end
   end
endmodule
`default_nettype wire

// File: cause_encoder.sv
`timescale 1ns/1ns
`default_nettype none
module cause_encoder
   import pmic_regs_pkg::*;
(
   input wire logic [pmic_regs_pkg::NUM_CAUSES-1:0] evt,
   input wire logic unknown,
   output logic valid,
   output logic [3:0] code
);
   // Walk from the top down so the lowest code is left standing
   always_comb begin
      valid = 1'b0;
      code = CAUSE_UNKNOWN;
      if (unknown) begin
         valid = 1'b1;
      end
      for (int i = NUM_CAUSES - 1; i >= 0; i--) begin
         if (evt[i]) begin
            valid = 1'b1;
            code = CAUSE_CODE[i];
         end
      end
   end
endmodule
`default_nettype wire

// File: pmic_unlock_and_fault_status.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Writing A5h to the unlock key register opens the other registers.
// - Bits 7:4 of restart cause hold the latest initialization cause.
// - Simultaneous faults record the lowest cause code.
// - Codes 0 to 4: first power-up, disable input, OV, UV, OC.
// - Codes 5, 6, 7: external regulator one, two, three lost good.
// - Code 8 is over-temperature; code 15 means unknown reason.
// - Bit 3 written one bypasses the settings-load guard, debug only.
// - Bit 2 written one erases the stored fault log.
// - Source flags: input bit 7, bucks bits 6..2, linear bit 1.
// - Good flags, one while in regulation, same bit layout.
// - Cause field read-only; bits 3..0 of that register writable.
// - Host reaches the registers through the serial target port.
module pmic_unlock_and_fault_status
   import pmic_regs_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic power_up_event,
   input wire logic power_disable_input,
   input wire logic over_voltage_fault,
   input wire logic under_voltage_fault,
   input wire logic over_current_fault,
   input wire logic ext_reg_one_good_input,
   input wire logic ext_reg_two_good_input,
   input wire logic ext_reg_three_good_input,
   input wire logic over_temp_fault,
   input wire logic unknown_restart,
   input wire logic restart_by_input_supply,
   input wire logic restart_by_buck_one,
   input wire logic restart_by_buck_two,
   input wire logic restart_by_buck_three,
   input wire logic restart_by_buck_four,
   input wire logic restart_by_buck_five,
   input wire logic restart_by_linear_reg,
   input wire logic input_supply_good,
   input wire logic buck_one_good,
   input wire logic buck_two_good,
   input wire logic buck_three_good,
   input wire logic buck_four_good,
   input wire logic buck_five_good,
   input wire logic linear_reg_good,
   output logic write_unlocked,
   output logic load_guard_bypass,
   output logic stored_fault_log_clear
);
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] synced;
   logic scl_s;
   logic sda_s;
   logic [NUM_CAUSES-1:0] lvl_s;
   logic unknown_s;
   logic [NUM_RAILS-1:0] source_s;
   logic [NUM_RAILS-1:0] good_s;

   // Every outside level passes two flops before use
   assign raw = {scl_in, sda_in,
      over_temp_fault, ext_reg_three_good_input, ext_reg_two_good_input,
      ext_reg_one_good_input, over_current_fault, under_voltage_fault,
      over_voltage_fault, power_disable_input, power_up_event,
      unknown_restart,
      restart_by_input_supply, restart_by_buck_one, restart_by_buck_two,
      restart_by_buck_three, restart_by_buck_four, restart_by_buck_five,
      restart_by_linear_reg,
      input_supply_good, buck_one_good, buck_two_good, buck_three_good,
      buck_four_good, buck_five_good, linear_reg_good};

   sync2 #(
      .W(SYNC_W)
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .d(raw),
      .q(synced)
   );

   // Split the synchronised word back into its groups
   assign {scl_s, sda_s, lvl_s, unknown_s, source_s, good_s} = synced;

   // Serial target state
   link_state_t st_q, st_d, nxt_q, nxt_d;
   logic [2:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic [7:0] ptr_q, ptr_d;
   logic rw_q, rw_d;
   logic nack_q, nack_d;
   logic oe_q, oe_d;
   logic scl_prev_q, scl_prev_d;
   logic sda_prev_q, sda_prev_d;
   logic wr_en;
   logic [7:0] wr_data;
   logic [7:0] rdata;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // Bus conditions, judged only on second-stage samples
   always_comb begin
      scl_rise = scl_s & ~scl_prev_q;
      scl_fall = ~scl_s & scl_prev_q;
      start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
      stop_seen = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
      wr_data = {sh_q[6:0], sda_s};
   end

   // Byte framing, acknowledge and pointer handling
   always_comb begin
      st_d = st_q;
      nxt_d = nxt_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      rw_d = rw_q;
      nack_d = nack_q;
      oe_d = oe_q;
      wr_en = 1'b0;
      scl_prev_d = scl_s;
      sda_prev_d = sda_s;
      if (start_seen) begin
         st_d = ST_ADDR;
         cnt_d = 3'h0;
         oe_d = 1'b0;
      end else if (stop_seen) begin
         st_d = ST_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               oe_d = 1'b0;
            end
            ST_ADDR, ST_PTR, ST_WDATA: begin
               if (scl_rise) begin
                  sh_d = wr_data;
                  cnt_d = cnt_q + 3'h1;
                  if (cnt_q == 3'h7) begin
                     st_d = ST_ACK;
                     if (st_q == ST_ADDR) begin
                        // Foreign address: drop off until next start
                        if (sh_q[6:0] == TARGET_ADDR) begin
                           rw_d = sda_s;
                           nxt_d = sda_s ? ST_RDATA : ST_PTR;
                        end else begin
                           st_d = ST_IDLE;
                        end
                     end else if (st_q == ST_PTR) begin
                        ptr_d = wr_data;
                        nxt_d = ST_WDATA;
                     end else begin
                        wr_en = 1'b1;
                        ptr_d = ptr_q + 8'h01;
                        nxt_d = ST_WDATA;
                     end
                  end
               end
            end
            ST_ACK: begin
               // Pull data low for the ninth clock
               if (scl_fall) begin
                  oe_d = 1'b1;
                  st_d = ST_ACKH;
               end
            end
            ST_ACKH: begin
               if (scl_fall) begin
                  cnt_d = 3'h0;
                  st_d = nxt_q;
                  if (nxt_q == ST_RDATA) begin
                     sh_d = rdata;
                     oe_d = ~rdata[7];
                  end else begin
                     oe_d = 1'b0;
                  end
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 3'h1;
               end else if (scl_fall) begin
                  if (cnt_q == 3'h0) begin
                     oe_d = 1'b0;
                     st_d = ST_RACK;
                  end else begin
                     sh_d = {sh_q[6:0], 1'b0};
                     oe_d = ~sh_q[6];
                  end
               end
            end
            ST_RACK: begin
               // Host acknowledge decides whether to send another byte
               if (scl_rise) begin
                  nack_d = sda_s;
                  if (!sda_s) begin
                     ptr_d = ptr_q + 8'h01;
                  end
               end else if (scl_fall) begin
                  if (nack_q) begin
                     st_d = ST_IDLE;
                  end else begin
                     sh_d = rdata;
                     oe_d = ~rdata[7];
                     cnt_d = 3'h0;
                     st_d = ST_RDATA;
                  end
               end
            end
            default: begin
               st_d = ST_IDLE;
               oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_q <= ST_IDLE;
         nxt_q <= ST_IDLE;
         cnt_q <= 3'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         oe_q <= 1'b0;
         scl_prev_q <= 1'b0;
         sda_prev_q <= 1'b0;
      end else begin
         st_q <= st_d;
         nxt_q <= nxt_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         rw_q <= rw_d;
         nack_q <= nack_d;
         oe_q <= oe_d;
         scl_prev_q <= scl_prev_d;
         sda_prev_q <= sda_prev_d;
      end
   end

   // Register file state
   logic [7:0] key_q, key_d;
   logic [3:0] ctrl_q, ctrl_d;
   logic [3:0] cause_q, cause_d;
   logic [NUM_RAILS-1:0] contrib_q, contrib_d;
   logic src_rsvd_q, src_rsvd_d;
   logic good_rsvd_q, good_rsvd_d;
   logic unl_q, unl_d;
   logic clear_q, clear_d;
   logic [NUM_CAUSES-1:0] lvl_prev_q, lvl_prev_d;
   logic unknown_prev_q, unknown_prev_d;
   logic [NUM_CAUSES-1:0] evt;
   logic unknown_evt;
   logic cause_valid;
   logic [3:0] cause_code;

   // Faults count on rising edge; regulator good inputs fail falling
   always_comb begin
      evt = lvl_s & ~lvl_prev_q;
      evt[5] = ~lvl_s[5] & lvl_prev_q[5];
      evt[6] = ~lvl_s[6] & lvl_prev_q[6];
      evt[7] = ~lvl_s[7] & lvl_prev_q[7];
      unknown_evt = unknown_s & ~unknown_prev_q;
   end

   cause_encoder u_enc (
      .evt(evt),
      .unknown(unknown_evt),
      .valid(cause_valid),
      .code(cause_code)
   );

   // Host writes, cause capture and the lock
   always_comb begin
      key_d = key_q;
      ctrl_d = ctrl_q;
      cause_d = cause_q;
      contrib_d = contrib_q;
      src_rsvd_d = src_rsvd_q;
      good_rsvd_d = good_rsvd_q;
      clear_d = 1'b0;
      lvl_prev_d = lvl_s;
      unknown_prev_d = unknown_s;
      if (wr_en) begin
         // Key register itself stays writable so the lock can open
         if (ptr_q == OFS_UNLOCK_KEY) begin
            key_d = wr_data;
         end else if (unl_q) begin
            if (ptr_q == OFS_RESTART_CAUSE) begin
               ctrl_d = wr_data[3:0];
               clear_d = wr_data[CLEAR_BIT];
            end else if (ptr_q == OFS_SOURCE_FLAGS) begin
               src_rsvd_d = wr_data[RSVD_BIT];
            end else if (ptr_q == OFS_RAIL_GOOD) begin
               good_rsvd_d = wr_data[RSVD_BIT];
            end
         end
      end
      // Hardware capture; host cannot touch these fields
      if (cause_valid) begin
         cause_d = cause_code;
         contrib_d = source_s;
      end
      unl_d = (key_d == UNLOCK_KEY_VALUE);
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      if (ptr_q == OFS_UNLOCK_KEY) begin
         rdata = key_q;
      end else if (ptr_q == OFS_RESTART_CAUSE) begin
         rdata = {cause_q, ctrl_q};
      end else if (ptr_q == OFS_SOURCE_FLAGS) begin
         rdata = {contrib_q, src_rsvd_q};
      end else if (ptr_q == OFS_RAIL_GOOD) begin
         rdata = {good_s, good_rsvd_q};
      end else begin
         rdata = UNMAPPED_READ;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         key_q <= KEY_RESET;
         ctrl_q <= CTRL_RESET;
         cause_q <= CAUSE_RESET;
         contrib_q <= FLAGS_RESET;
         src_rsvd_q <= RSVD_RESET;
         good_rsvd_q <= RSVD_RESET;
         unl_q <= 1'b0;
         clear_q <= 1'b0;
         lvl_prev_q <= '0;
         unknown_prev_q <= 1'b0;
      end else begin
         key_q <= key_d;
         ctrl_q <= ctrl_d;
         cause_q <= cause_d;
         contrib_q <= contrib_d;
         src_rsvd_q <= src_rsvd_d;
         good_rsvd_q <= good_rsvd_d;
         unl_q <= unl_d;
         clear_q <= clear_d;
         lvl_prev_q <= lvl_prev_d;
         unknown_prev_q <= unknown_prev_d;
      end
   end

   // Open-drain data: only ever pulled low
   always_ff @(posedge clk) begin
      sda_out <= 1'b0;
   end

   assign sda_oe = oe_q;
   assign write_unlocked = unl_q;
   assign load_guard_bypass = ctrl_q[BYPASS_BIT];
   assign stored_fault_log_clear = clear_q;
endmodule
`default_nettype wire

// File: pmic_unlock_and_fault_status_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pmic_unlock_and_fault_status_monitor (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic write_unlocked,
   input wire logic load_guard_bypass,
   input wire logic stored_fault_log_clear
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // Reset leaves the bus released and the unlock and bypass controls quiet
   AST_RESET_QUIET: assert property (disable iff (1'b0)
      sys_rst |=> !(sda_oe | write_unlocked | load_guard_bypass))
      else $error("outputs not quiet after reset");
   // Erase command is a single-cycle strobe
   AST_CLEAR_ONE_CYCLE: assert property (
      stored_fault_log_clear |=> !stored_fault_log_clear)
      else $error("erase strobe longer than one cycle");
   // Erase only fires from an unlocked write
   AST_CLEAR_NEEDS_KEY: assert property (
      stored_fault_log_clear |-> write_unlocked || $past(write_unlocked))
      else $error("erase strobe while locked");
   // Bypass bit moves only while unlocked
   AST_BYPASS_NEEDS_KEY: assert property (
      $changed(load_guard_bypass) |-> $past(write_unlocked))
      else $error("bypass changed while locked");
   // Data drive may only move while the serial clock is low
   AST_OE_MOVES_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data drive changed with clock high");
   // A driven bit stands for more than a few cycles
   AST_OE_HOLDS: assert property ($rose(sda_oe) |=> sda_oe [*3])
      else $error("data drive too short");
   // Driving always pulls the line low
   AST_SDA_LOW: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("driving high on open-drain line");
   // Key and bypass settle early in a clock-high phase, never late
   AST_STABLE_SCL_HIGH: assert property (
      scl_in [*8] |-> $stable({write_unlocked, load_guard_bypass}))
      else $error("control changed late in clock high");
endmodule
bind pmic_unlock_and_fault_status
   pmic_unlock_and_fault_status_monitor u_mon (.clk, .sys_rst, .scl_in,
   .sda_out, .sda_oe, .write_unlocked, .load_guard_bypass,
   .stored_fault_log_clear);
`default_nettype wire

// File: i2c_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_host_model
   import pmic_regs_pkg::*;
(
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_oe
);
   int hp = 8; // Half bit in clocks; raised for a slow host
   // Bus idles released until the bench talks, after supply is up
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Start and repeated start: data falls while clock high
   task automatic start();
      sda_oe = 1'b0;
      wt(hp);
      scl = 1'b1;
      wt(hp);
      sda_oe = 1'b1;
      wt(hp);
      scl = 1'b0;
   endtask
   task automatic stop();
      sda_oe = 1'b1;
      wt(hp);
      scl = 1'b1;
      wt(hp);
      sda_oe = 1'b0;
      wt(hp);
   endtask
   // Data changes mid-low, sampled at end of high
   task automatic xbit(input logic b, output logic r);
      wt(hp / 2);
      sda_oe = ~b;
      wt(hp / 2);
      scl = 1'b1;
      wt(hp);
      r = sda;
      scl = 1'b0;
   endtask
   // MSB first, ninth bit is the acknowledge
   task automatic xbyte(input logic [7:0] d, input logic nak,
                        output logic [7:0] r, output logic ack);
      for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
      xbit(nak, ack);
      ack = ~ack;
   endtask
   task automatic wr(input logic [7:0] o, input logic [7:0] d,
                     output logic ok);
      logic [7:0] r;
      logic a0, a1, a2;
      start();
      xbyte({TARGET_ADDR, 1'b0}, 1'b1, r, a0);
      xbyte(o, 1'b1, r, a1);
      xbyte(d, 1'b1, r, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   task automatic rd(input logic [7:0] o, output logic [7:0] d,
                     output logic ok);
      logic [7:0] r;
      logic a0, a1, a2, n;
      start();
      xbyte({TARGET_ADDR, 1'b0}, 1'b1, r, a0);
      xbyte(o, 1'b1, r, a1);
      start();
      xbyte({TARGET_ADDR, 1'b1}, 1'b1, r, a2);
      xbyte(8'hff, 1'b1, d, n);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import pmic_regs_pkg::*;
   logic clk, sys_rst, unk, scl, host_oe, sda_out, dut_oe, sda;
   logic [8:0] evt;
   logic [6:0] src, good;
   logic write_unlocked, load_guard_bypass, stored_fault_log_clear;
   int mismatches = 0;
   int checked = 0;
   int clears = 0;
   // Open-drain data line with pull-up
   assign sda = (dut_oe ? sda_out : 1'b1) && !host_oe;
   i2c_host_model u_host (.clk(clk), .sda(sda), .scl(scl),
      .sda_oe(host_oe));
   pmic_unlock_and_fault_status u_dut (.clk(clk), .sys_rst(sys_rst),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(dut_oe),
      .power_up_event(evt[0]), .power_disable_input(evt[1]),
      .over_voltage_fault(evt[2]), .under_voltage_fault(evt[3]),
      .over_current_fault(evt[4]), .ext_reg_one_good_input(~evt[5]),
      .ext_reg_two_good_input(~evt[6]), .ext_reg_three_good_input(~evt[7]),
      .over_temp_fault(evt[8]), .unknown_restart(unk),
      .restart_by_input_supply(src[6]), .restart_by_buck_one(src[5]),
      .restart_by_buck_two(src[4]), .restart_by_buck_three(src[3]),
      .restart_by_buck_four(src[2]), .restart_by_buck_five(src[1]),
      .restart_by_linear_reg(src[0]), .input_supply_good(good[6]),
      .buck_one_good(good[5]), .buck_two_good(good[4]),
      .buck_three_good(good[3]), .buck_four_good(good[2]),
      .buck_five_good(good[1]), .linear_reg_good(good[0]),
      .write_unlocked(write_unlocked), .load_guard_bypass(load_guard_bypass),
      .stored_fault_log_clear(stored_fault_log_clear));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Count erase strobes mid-cycle, away from the launching edge
   always @(negedge clk) begin
      if (stored_fault_log_clear === 1'b1) clears++;
   end
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic w(input logic [7:0] o, input logic [7:0] d);
      logic ok;
      u_host.wr(o, d, ok);
      chk("write ack", 8'h01, {7'h00, ok});
   endtask
   task automatic r(input logic [7:0] o, input string nm, input logic [7:0] e);
      logic ok;
      logic [7:0] d;
      u_host.rd(o, d, ok);
      chk("read ack", 8'h01, {7'h00, ok});
      chk(nm, e, d);
   endtask
   // Events are held a few cycles so the synchronisers catch them
   task automatic fire(input logic [8:0] e, input logic u);
      evt = e;
      unk = u;
      repeat (6) @(negedge clk);
      evt = '0;
      unk = 1'b0;
      repeat (6) @(negedge clk);
   endtask
   task automatic t_reset();
      logic [7:0] d;
      logic a;
      r(OFS_UNLOCK_KEY, "key", KEY_RESET);
      r(OFS_RESTART_CAUSE, "cause", 8'h00);
      r(8'h10, "unmapped", UNMAPPED_READ);
      u_host.start();
      u_host.xbyte({TARGET_ADDR ^ 7'h01, 1'b0}, 1'b1, d, a);
      u_host.stop();
      chk("foreign address ack", 8'h00, {7'h00, a});
      $display("test reset done");
   endtask
   task automatic t_locked();
      w(OFS_RESTART_CAUSE, 8'h0f);
      r(OFS_RESTART_CAUSE, "locked cause", 8'h00);
      chk("locked bypass", 8'h00, {7'h00, load_guard_bypass});
      chk("locked clears", 8'h00, 8'(clears));
      $display("test locked done");
   endtask
   task automatic t_ctrl();
      w(OFS_UNLOCK_KEY, UNLOCK_KEY_VALUE);
      chk("unlocked", 8'h01, {7'h00, write_unlocked});
      r(OFS_UNLOCK_KEY, "key", UNLOCK_KEY_VALUE);
      u_host.hp = 16;
      w(OFS_RESTART_CAUSE, 8'hff);
      r(OFS_RESTART_CAUSE, "cause ro", 8'h0f);
      chk("bypass set", 8'h01, {7'h00, load_guard_bypass});
      chk("erase strobes", 8'h01, 8'(clears));
      u_host.hp = 8;
      w(OFS_RESTART_CAUSE, 8'h03);
      chk("bypass clear", 8'h00, {7'h00, load_guard_bypass});
      chk("erase strobes", 8'h01, 8'(clears));
      $display("test control done");
   endtask
   task automatic t_causes();
      for (int i = 8; i >= 0; i--) begin
         src = 7'(1 << (i % 7));
         fire(9'(1 << i), 1'b0);
         src = '0;
         r(OFS_RESTART_CAUSE, "cause", {CAUSE_CODE[i], 4'h3});
         r(OFS_SOURCE_FLAGS, "sources", {7'(1 << (i % 7)), 1'b0});
      end
      fire(9'h148, 1'b0);
      r(OFS_RESTART_CAUSE, "priority", {CAUSE_UNDER_VOLTAGE, 4'h3});
      fire(9'h000, 1'b1);
      r(OFS_RESTART_CAUSE, "unknown", {CAUSE_UNKNOWN, 4'h3});
      fire(9'h010, 1'b1);
      r(OFS_RESTART_CAUSE, "coded first", {CAUSE_OVER_CURRENT, 4'h3});
      $display("test causes done");
   endtask
   task automatic t_good();
      good = 7'h53;
      r(OFS_RAIL_GOOD, "good", 8'ha6);
      good = 7'h2c;
      r(OFS_RAIL_GOOD, "good", 8'h58);
      w(OFS_UNLOCK_KEY, 8'h5a);
      chk("relocked", 8'h00, {7'h00, write_unlocked});
      w(OFS_RESTART_CAUSE, 8'h08);
      r(OFS_RESTART_CAUSE, "relocked cause", 8'h43);
      $display("test good and relock done");
   endtask
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      $display("[ERR] run length expected done seen hung");
      end_of_test();
   end
   initial begin
      sys_rst = 1'b1;
      evt = '0;
      unk = 1'b0;
      src = '0;
      good = 7'h7f;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      t_reset();
      t_locked();
      t_ctrl();
      t_causes();
      t_good();
      end_of_test();
   end
endmodule
`default_nettype wire
